// [hdl/ams_dev.sv]
// Drive-side decoder for max-limit protection, multiple block size and sleep.
`timescale 1ns/1ps
module ams_dev
   import ams_pkg::*;
#(
   parameter int WORDS = SECTOR_WORDS
) (
   input wire logic CLK,
   input wire logic RST_B,
   ams_tf_if.dev TF,
   input wire logic SECT_DONE,
   input wire logic SPUN_DOWN,
   output logic SPIN_DOWN,
   output logic SLEEPING,
   output logic MULT_EN,
   output logic [7:0] MULT_BLK,
   output ams_max_t MAX_STATE,
   output logic [2:0] UNLOCK_LEFT
);
   localparam int IW = $clog2(WORDS);

   typedef enum logic [1:0] {ST_IDLE, ST_RXPW, ST_SLEEP} ams_st_t;

   typedef struct packed {
      ams_st_t st;
      ams_max_t max;
      logic after_native;
      logic pw_unlock;
      logic pw_match;
      logic [PWD_WORDS-1:0][15:0] pwd;
      logic [2:0] tries;
      logic mult_en;
      logic [7:0] blk;
      logic [7:0] sect;
      logic [7:0] status;
      logic [7:0] error;
      logic intrq;
      logic spin_down;
      logic sleeping;
   } ams_dev_t;

   ams_dev_t r;
   ams_dev_t n;
   logic rx_start;
   logic rx_busy;
   logic rx_done;
   logic [IW-1:0] rx_idx;
   logic [7:0] widx;
   logic in_pwd;
   logic [3:0] pslot;

   ////////////////////////////////////////////////////////////////////////////
   // Password sector reception.
   ams_sector_rx #(.WORDS(WORDS)) u_rx (
      .CLK(CLK),
      .RST_B(RST_B),
      .start(rx_start),
      .abort(TF.srst || TF.hrst),
      .word_stb(TF.wr_stb),
      .busy(rx_busy),
      .idx(rx_idx),
      .done(rx_done)
   );

   // Word index widened to byte width; password slot is index minus one.
   assign widx = 8'(rx_idx);
   assign in_pwd = (widx >= PWD_FIRST) && (widx <= PWD_LAST);
   assign pslot = 4'(widx - PWD_FIRST);
   assign rx_start = (n.st == ST_RXPW) && (r.st != ST_RXPW);

   ////////////////////////////////////////////////////////////////////////////
   // Command decode and completion; each command finishes in one cycle
   // except the password sector, which holds busy with data request.
   always_comb begin
      logic ok;
      logic fin;
      ok = 1'b0;
      fin = 1'b0;
      n = r;
      n.intrq = 1'b0;
      n.spin_down = 1'b0;
      // Sector counting for multiple transfers.
      if (SECT_DONE) begin
         if (!r.mult_en || (r.sect + 8'h01 >= r.blk)) begin
            n.sect = '0;
            n.intrq = 1'b1;
         end else begin
            n.sect = r.sect + 8'h01;
         end
      end
      if (TF.hrst) begin
         n.tries = UNLOCK_TRIES;
         n.st = ST_IDLE;
         n.status = 8'h00;
         n.status[ST_RDY] = 1'b1;
         n.after_native = 1'b0;
      end else if (TF.srst) begin
         n.st = ST_IDLE;
         n.status = 8'h00;
         n.status[ST_RDY] = 1'b1;
         n.after_native = 1'b0;
      end else begin
         unique case (r.st)
            ST_IDLE: begin
               if (TF.cmd_stb) begin
                  fin = 1'b1;
                  n.after_native = (TF.cmd == CMD_RD_NATIVE);
                  if (TF.cmd == CMD_RD_NATIVE) begin
                     ok = 1'b1;
                  end else if (TF.cmd == CMD_SETMAX && r.after_native) begin
                     ok = (r.max == MAX_UNLK);
                  end else if (TF.cmd == CMD_SETMAX) begin
                     if (TF.feat == FEAT_SETPW && r.max == MAX_UNLK) begin
                        fin = 1'b0;
                        n.pw_unlock = 1'b0;
                        n.st = ST_RXPW;
                     end else if (TF.feat == FEAT_LOCK && r.max == MAX_UNLK) begin
                        ok = 1'b1;
                        n.max = MAX_LOCKD;
                     end else if (TF.feat == FEAT_UNLOCK && r.max != MAX_FROZ
                                  && r.tries != TRIES_NONE) begin
                        fin = 1'b0;
                        n.pw_unlock = 1'b1;
                        n.pw_match = 1'b1;
                        n.st = ST_RXPW;
                     end else if (TF.feat == FEAT_FREEZE && r.max != MAX_FROZ) begin
                        ok = 1'b1;
                        n.max = MAX_FROZ;
                     end
                  end else if (TF.cmd == CMD_SETMULT) begin
                     ok = (TF.cnt == BLK_0) || (TF.cnt == BLK_2) || (TF.cnt == BLK_4)
                          || (TF.cnt == BLK_8) || (TF.cnt == BLK_16);
                     n.mult_en = ok && (TF.cnt != BLK_0);
                     n.blk = ok ? TF.cnt : BLK_0;
                     n.sect = '0;
                  end else if (TF.cmd == CMD_SLEEP_A || TF.cmd == CMD_SLEEP_B) begin
                     ok = 1'b1;
                     n.spin_down = !SPUN_DOWN;
                     n.st = ST_SLEEP;
                  end
               end
            end
            ST_RXPW: begin
               if (TF.wr_stb && rx_busy && in_pwd) begin
                  if (r.pw_unlock) begin
                     n.pw_match = r.pw_match && (TF.wr_word == r.pwd[pslot]);
                  end else begin
                     n.pwd[pslot] = TF.wr_word;
                  end
               end
               if (rx_done) begin
                  fin = 1'b1;
                  n.st = ST_IDLE;
                  if (!r.pw_unlock || r.pw_match) begin
                     ok = 1'b1;
                     n.max = MAX_UNLK;
                  end else begin
                     n.tries = r.tries - 3'h1;
                  end
               end
            end
            ST_SLEEP: begin
               // Interface inactive: commands are ignored until a reset.
            end
         endcase
      end
      // Busy and data request while the sector is expected; decoded from the
      // next state here so the process never reads a net built from its own output.
      if (n.st == ST_RXPW && r.st != ST_RXPW) begin
         n.status[ST_BSY] = 1'b1;
         n.status[ST_DRQ] = 1'b1;
      end
      // Completion: abort reports ABT and ERR, and the interrupt rises in the same cycle.
      if (fin) begin
         n.intrq = 1'b1;
         n.status = 8'h00;
         n.status[ST_RDY] = 1'b1;
         n.status[ST_DSC] = 1'b1;
         n.status[ST_ERR] = !ok;
         n.error = 8'h00;
         n.error[ER_ABT] = !ok;
      end
      // Registered copy of the sleep state so the output comes from a flop.
      n.sleeping = (n.st == ST_SLEEP);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; the password is only lost at power-on, the counter also reloads on a hard reset.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.max <= MAX_UNLK;
         r.tries <= UNLOCK_TRIES;
         r.status <= 8'h40;
      end else begin
         r <= n;
      end
   end

   assign TF.status = r.status;
   assign TF.error = r.error;
   assign TF.intrq = r.intrq;
   assign SPIN_DOWN = r.spin_down;
   assign SLEEPING = r.sleeping;
   assign MULT_EN = r.mult_en;
   assign MULT_BLK = r.blk;
   assign MAX_STATE = r.max;
   assign UNLOCK_LEFT = r.tries;
endmodule : ams_dev

// [hdl/ams_pkg.sv]
// Shared constants and types for the max-limit, multiple and sleep command block.
package ams_pkg;
   // Command bytes.
   localparam logic [7:0] CMD_SETMAX = 8'hf9;
   localparam logic [7:0] CMD_SETMULT = 8'hc6;
   localparam logic [7:0] CMD_SLEEP_A = 8'he6;
   localparam logic [7:0] CMD_SLEEP_B = 8'h99;
   // Read-native-max opcode; the value is a plain default.
   localparam logic [7:0] CMD_RD_NATIVE = 8'hf8;
   // Feature codes of the max-limit subcommands.
   localparam logic [7:0] FEAT_SETPW = 8'h01;
   localparam logic [7:0] FEAT_LOCK = 8'h02;
   localparam logic [7:0] FEAT_UNLOCK = 8'h03;
   localparam logic [7:0] FEAT_FREEZE = 8'h04;
   // Unlock attempts after reset, password word window, sector length.
   localparam logic [2:0] UNLOCK_TRIES = 3'h5;
   localparam logic [2:0] TRIES_NONE = 3'h0;
   localparam int PWD_WORDS = 16;
   localparam logic [7:0] PWD_FIRST = 8'h01;
   localparam logic [7:0] PWD_LAST = 8'h10;
   localparam int SECTOR_WORDS = 256;
   // Legal multiple block sizes.
   localparam logic [7:0] BLK_0 = 8'h00;
   localparam logic [7:0] BLK_2 = 8'h02;
   localparam logic [7:0] BLK_4 = 8'h04;
   localparam logic [7:0] BLK_8 = 8'h08;
   localparam logic [7:0] BLK_16 = 8'h10;
   // Status and error bit positions.
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_ABT = 2;
   // Host controller register byte addresses.
   localparam logic [4:0] A_CTRL = 5'h00;
   localparam logic [4:0] A_DATA = 5'h04;
   localparam logic [4:0] A_STAT = 5'h08;
   localparam logic [4:0] A_IRQ = 5'h0c;
   localparam logic [4:0] A_MASK = 5'h10;
   // Control and status register fields.
   localparam int CTRL_FEAT = 8;
   localparam int CTRL_CNT = 16;
   localparam int CTRL_SRST = 24;
   localparam int CTRL_HRST = 25;
   localparam int STAT_ERR = 8;
   localparam int STAT_DRQ = 16;
   localparam int STAT_BUSY = 17;
   // Interrupt status bits.
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_BITS = 2;
   typedef enum logic [1:0] {MAX_UNLK, MAX_LOCKD, MAX_FROZ} ams_max_t;
endpackage : ams_pkg

// [hdl/ams_tf_if.sv]
// Task-file link between the host controller and the drive command logic.
`timescale 1ns/1ps
interface ams_tf_if;
   logic cmd_stb;
   logic [7:0] cmd;
   logic [7:0] feat;
   logic [7:0] cnt;
   logic wr_stb;
   logic [15:0] wr_word;
   logic srst;
   logic hrst;
   logic [7:0] status;
   logic [7:0] error;
   logic intrq;
   modport dev (input cmd_stb, cmd, feat, cnt, wr_stb, wr_word, srst, hrst,
                output status, error, intrq);
   modport hst (output cmd_stb, cmd, feat, cnt, wr_stb, wr_word, srst, hrst,
                input status, error, intrq);
endinterface : ams_tf_if

// [hdl/ams_sector_rx.sv]
// Counter that tracks the words of one sector coming in from the host.
`timescale 1ns/1ps
module ams_sector_rx
   import ams_pkg::*;
#(
   parameter int WORDS = SECTOR_WORDS
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic start,
   input wire logic abort,
   input wire logic word_stb,
   output logic busy,
   output logic [$clog2(WORDS)-1:0] idx,
   output logic done
);
   localparam int IW = $clog2(WORDS);
   localparam logic [IW-1:0] LAST = IW'(WORDS - 1);

   typedef struct packed {
      logic busy;
      logic [IW-1:0] idx;
      logic done;
   } ams_rx_t;

   ams_rx_t r;
   ams_rx_t n;

   ////////////////////////////////////////////////////////////////////////////
   // Abort beats start so a reset mid-sector never leaves a stale transfer.
   always_comb begin
      n = r;
      n.done = 1'b0;
      if (abort) begin
         n.busy = 1'b0;
      end else if (start) begin
         n.busy = 1'b1;
         n.idx = '0;
      end else if (r.busy && word_stb) begin
         n.idx = r.idx + 1'b1;
         if (r.idx == LAST) begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign busy = r.busy;
   assign idx = r.idx;
   assign done = r.done;
endmodule : ams_sector_rx

// [hdl/ams_host.sv]
// Host controller: Avalon-MM register slave that drives the task-file link.
`timescale 1ns/1ps
module ams_host
   import ams_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic IRQ,
   ams_tf_if.hst TF
);
   typedef struct packed {
      logic wait_n;
      logic [31:0] rdata;
      logic [IRQ_BITS-1:0] irq_st;
      logic [IRQ_BITS-1:0] irq_mask;
      logic irq;
      logic cmd_stb;
      logic [7:0] cmd;
      logic [7:0] feat;
      logic [7:0] cnt;
      logic wr_stb;
      logic [15:0] wr_word;
      logic srst;
      logic hrst;
   } ams_host_t;

   ams_host_t r;
   ams_host_t n;

   ////////////////////////////////////////////////////////////////////////////
   // One access per request: waitrequest drops for one cycle when served.
   // A data write stalls until the drive asks for data, which throttles
   // software to the drive's pace without a buffer.
   always_comb begin
      logic go;
      logic [IRQ_BITS-1:0] set;
      logic [IRQ_BITS-1:0] clr;
      go = 1'b0;
      set = '0;
      clr = '0;
      n = r;
      n.wait_n = 1'b0;
      n.cmd_stb = 1'b0;
      n.wr_stb = 1'b0;
      n.srst = 1'b0;
      n.hrst = 1'b0;
      if ((AVS_READ || AVS_WRITE) && !r.wait_n) begin
         go = !(AVS_WRITE && AVS_ADDRESS == A_DATA && !TF.status[ST_DRQ]);
      end
      if (go) begin
         n.wait_n = 1'b1;
         n.rdata = 32'h0000_0000;
         if (AVS_WRITE) begin
            unique case (AVS_ADDRESS)
               A_CTRL: begin
                  n.cmd = AVS_WRITEDATA[7:0];
                  n.feat = AVS_WRITEDATA[CTRL_FEAT +: 8];
                  n.cnt = AVS_WRITEDATA[CTRL_CNT +: 8];
                  n.srst = AVS_WRITEDATA[CTRL_SRST];
                  n.hrst = AVS_WRITEDATA[CTRL_HRST];
                  n.cmd_stb = !(AVS_WRITEDATA[CTRL_SRST] || AVS_WRITEDATA[CTRL_HRST]);
               end
               A_DATA: begin
                  n.wr_word = AVS_WRITEDATA[15:0];
                  n.wr_stb = 1'b1;
               end
               A_IRQ: clr = AVS_WRITEDATA[IRQ_BITS-1:0];
               A_MASK: n.irq_mask = AVS_WRITEDATA[IRQ_BITS-1:0];
               default: begin
               end
            endcase
         end else begin
            unique case (AVS_ADDRESS)
               A_STAT: begin
                  n.rdata[7:0] = TF.status;
                  n.rdata[STAT_ERR +: 8] = TF.error;
                  n.rdata[STAT_DRQ] = TF.status[ST_DRQ];
                  n.rdata[STAT_BUSY] = TF.status[ST_BSY];
               end
               A_IRQ: n.rdata[IRQ_BITS-1:0] = r.irq_st;
               A_MASK: n.rdata[IRQ_BITS-1:0] = r.irq_mask;
               default: n.rdata = 32'h0000_0000;
            endcase
         end
      end
      // Drive events; a new event wins over a clear in the same cycle.
      set[IRQ_DONE] = TF.intrq;
      set[IRQ_ERR] = TF.intrq && TF.status[ST_ERR];
      n.irq_st = (r.irq_st & ~clr) | set;
      n.irq = |(n.irq_st & n.irq_mask);
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign AVS_READDATA = r.rdata;
   assign AVS_WAITREQUEST = !r.wait_n;
   assign IRQ = r.irq;
   assign TF.cmd_stb = r.cmd_stb;
   assign TF.cmd = r.cmd;
   assign TF.feat = r.feat;
   assign TF.cnt = r.cnt;
   assign TF.wr_stb = r.wr_stb;
   assign TF.wr_word = r.wr_word;
   assign TF.srst = r.srst;
   assign TF.hrst = r.hrst;
endmodule : ams_host

// [tb/ams_tf_assertions.sv]
// Assertion checker for the task-file link between host and drive logic.
`timescale 1ns/1ps
module ams_tf_assertions
   import ams_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic cmd_stb,
   input wire logic [7:0] cmd,
   input wire logic [7:0] feat,
   input wire logic [7:0] cnt,
   input wire logic wr_stb,
   input wire logic srst,
   input wire logic hrst,
   input wire logic [7:0] status,
   input wire logic [7:0] error,
   input wire logic intrq
);
   ////////////////////////////////////////////////////////////////////////////////
   logic sleep_r;
   logic nat_r;
   logic [8:0] wcnt_r;
   wire tk = cmd_stb && !sleep_r && !status[ST_BSY];
   wire ok_blk = cnt inside {BLK_0, BLK_2, BLK_4, BLK_8, BLK_16};
   // The link cannot show sleep or the read-native flag, so they are tracked here.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         sleep_r <= 1'b0;
         nat_r <= 1'b0;
         wcnt_r <= 9'h000;
      end else begin
         if (srst || hrst) begin
            sleep_r <= 1'b0;
         end else if (tk && (cmd == CMD_SLEEP_A || cmd == CMD_SLEEP_B)) begin
            sleep_r <= 1'b1;
         end
         // A link reset clears the read-native flag in the drive as well.
         if (srst || hrst) begin
            nat_r <= 1'b0;
         end else if (tk) begin
            nat_r <= (cmd == CMD_RD_NATIVE);
         end
         wcnt_r <= cmd_stb ? 9'h000 : wcnt_r + {8'h00, wr_stb};
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   sequence s_tk(logic [7:0] c);
      tk && cmd == c;
   endsequence
   sequence s_done(logic [7:0] st);
      intrq && status == st;
   endsequence
   a_mult_ok: assert property (s_tk(CMD_SETMULT) ##0 ok_blk
      |=> s_done(8'h50) ##0 error == 8'h00) else $error("Legal block size refused.");
   a_mult_bad: assert property (s_tk(CMD_SETMULT) ##0 !ok_blk
      |=> s_done(8'h51) ##0 error == 8'h04) else $error("Illegal block size not aborted.");
   // Busy and data request are added to the previous status bits, so only those two are checked.
   a_unlock_req: assert property (s_tk(CMD_SETMAX) ##0 feat == FEAT_UNLOCK && !nat_r
      |=> (status[ST_BSY] && status[ST_DRQ]) or (s_done(8'h51) ##0 error == 8'h04))
      else $error("Unlock not decoded.");
   a_native_setmax: assert property (s_tk(CMD_SETMAX) ##0 nat_r
      |=> intrq && !status[ST_BSY] && !status[ST_DRQ]) else $error("Set-max asked for data.");
   // The sector counter flags its end one cycle late, so completion shows two edges on.
   a_sector_end: assert property (wr_stb && wcnt_r == 9'd255 && status[ST_BSY]
      |-> ##2 intrq && !status[ST_BSY] && status[ST_RDY]) else $error("No completion after sector.");
   a_sleep_enter: assert property (s_tk(CMD_SLEEP_A) or s_tk(CMD_SLEEP_B)
      |=> s_done(8'h50)) else $error("Sleep not completed.");
   a_sleep_quiet: assert property (sleep_r && cmd_stb |=> !intrq ##1 !intrq)
      else $error("Command served while asleep.");
   a_abort_flags: assert property ($rose(error[ER_ABT])
      |-> status[ST_ERR] && !status[ST_BSY] && intrq) else $error("Abort without error completion.");
endmodule : ams_tf_assertions

// [tb/tb.sv]
// Self-checking bench for the host controller and drive command logic.
`timescale 1ns/1ps
module tb
   import ams_pkg::*;
;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   logic [4:0] addr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wreq;
   logic irq;
   logic sect_done = 1'b0;
   logic spun_down = 1'b0;
   logic spin_down, sleeping, mult_en;
   logic [7:0] mult_blk;
   ams_max_t max_state;
   logic [2:0] left;
   logic [31:0] rv;
   logic [15:0] pw [1:16];
   int num_errors = 0;
   int total_checks = 0;
   int seed = 32'h2baa;
   int cycles = 0;
   int nirq = 0;
   int nspin = 0;
   ams_tf_if tf();
   ams_host u_ams_host(.CLK(CLK), .RST_B(RST_B), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
      .IRQ(irq), .TF(tf));
   ams_dev u_ams_dev(.CLK(CLK), .RST_B(RST_B), .TF(tf), .SECT_DONE(sect_done),
      .SPUN_DOWN(spun_down), .SPIN_DOWN(spin_down), .SLEEPING(sleeping), .MULT_EN(mult_en),
      .MULT_BLK(mult_blk), .MAX_STATE(max_state), .UNLOCK_LEFT(left));
   ams_tf_assertions u_ams_tf_assertions(.CLK(CLK), .RST_B(RST_B), .cmd_stb(tf.cmd_stb),
      .cmd(tf.cmd), .feat(tf.feat), .cnt(tf.cnt), .wr_stb(tf.wr_stb), .srst(tf.srst),
      .hrst(tf.hrst), .status(tf.status), .error(tf.error), .intrq(tf.intrq));
   ////////////////////////////////////////////////////////////////////////////////
   // A 5 ns clock.
   always #2.5 CLK = ~CLK;
   // Pulse counters and the hang limit; seven sectors need well under 40000 cycles.
   always @(posedge CLK) begin
      cycles++;
      nirq += (tf.intrq === 1'b1);
      nspin += (spin_down === 1'b1);
      if (cycles == 40000) begin
         num_errors++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One Avalon transfer, held until waitrequest is sampled low.
   task av(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge CLK);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      do @(posedge CLK); while (wreq !== 1'b0);
      rv = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : av
   // A write followed by a settling gap, so device outputs are current afterwards.
   task wrs(input logic [4:0] a, input logic [31:0] d);
      av(1'b1, a, d);
      repeat (2) @(posedge CLK);
   endtask : wrs
   task cmd(input logic [7:0] c, input logic [7:0] f, input logic [7:0] n);
      wrs(A_CTRL, {8'h00, n, f, c});
   endtask : cmd
   task stat_is(input logic [15:0] exp);
      av(1'b0, A_STAT, 32'h0);
      check(32'(rv[15:0]), 32'(exp));
   endtask : stat_is
   // A wrong password differs only in the lowest bit of the last password word.
   task sector(input logic good);
      logic [15:0] w;
      for (int i = 0; i < SECTOR_WORDS; i++) begin
         w = 16'($random(seed));
         if (i >= 1 && i <= PWD_WORDS) w = pw[i] ^ {15'h0, !good && i == PWD_WORDS};
         av(1'b1, A_DATA, {16'h0, w});
      end
   endtask : sector
   function automatic logic legal(input logic [7:0] n);
      return n inside {BLK_0, BLK_2, BLK_4, BLK_8, BLK_16};
   endfunction : legal
   task final_report;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: multiple, interrupts, max-limit protection, sleep.
   initial begin
      logic [7:0] n;
      static logic [7:0] blks [7] = '{BLK_0, BLK_2, BLK_4, BLK_8, BLK_16, 8'h03, 8'h01};
      static logic [7:0] bad [3] = '{FEAT_SETPW, FEAT_LOCK, FEAT_UNLOCK};
      for (int i = 1; i <= PWD_WORDS; i++) pw[i] = 16'($random(seed));
      repeat (8) @(posedge CLK);
      RST_B <= 1'b1;
      check(32'(left), 32'(UNLOCK_TRIES));
      wrs(A_MASK, 32'h3);
      for (int k = 0; k < 10; k++) begin
         n = k < 7 ? blks[k] : 8'($random(seed));
         cmd(CMD_SETMULT, 8'h00, n);
         stat_is(legal(n) ? 16'h0050 : 16'h0451);
         check(32'(mult_en), 32'(legal(n) && n != BLK_0));
      end
      wrs(A_IRQ, 32'h3);
      cmd(CMD_SETMULT, 8'h00, 8'h11);
      av(1'b0, A_IRQ, 32'h0);
      check(32'(rv[IRQ_ERR]), 32'h1);
      check(32'(irq), 32'h1);
      wrs(A_MASK, 32'h0);
      check(32'(irq), 32'h0);
      wrs(A_MASK, 32'h3);
      wrs(A_IRQ, 32'h3);
      check(32'(irq), 32'h0);
      cmd(CMD_SETMULT, 8'h00, BLK_4);
      check(32'(mult_blk), 32'(BLK_4));
      nirq = 0;
      repeat (8) begin
         sect_done <= 1'b1;
         @(posedge CLK);
         sect_done <= 1'b0;
         repeat (3) @(posedge CLK);
      end
      check(nirq, 2);
      $display("test multiple done");
      cmd(CMD_RD_NATIVE, 8'h00, 8'h00);
      cmd(CMD_SETMAX, FEAT_FREEZE, 8'h00);
      stat_is(16'h0050);
      check(32'(max_state), 32'(MAX_UNLK));
      cmd(CMD_SETMAX, FEAT_SETPW, 8'h00);
      sector(1'b1);
      stat_is(16'h0050);
      cmd(CMD_SETMAX, FEAT_LOCK, 8'h00);
      check(32'(max_state), 32'(MAX_LOCKD));
      cmd(CMD_SETMAX, FEAT_LOCK, 8'h00);
      stat_is(16'h0451);
      for (int k = 0; k < 5; k++) begin
         cmd(CMD_SETMAX, FEAT_UNLOCK, 8'h00);
         sector(1'b0);
         stat_is(16'h0451);
         check(32'(left), 32'(4 - k));
      end
      cmd(CMD_SETMAX, FEAT_UNLOCK, 8'h00);
      stat_is(16'h0451);
      wrs(A_CTRL, 32'h1 << CTRL_HRST);
      check(32'(left), 32'(UNLOCK_TRIES));
      check(32'(max_state), 32'(MAX_LOCKD));
      cmd(CMD_SETMAX, FEAT_UNLOCK, 8'h00);
      sector(1'b1);
      stat_is(16'h0050);
      check(32'(max_state), 32'(MAX_UNLK));
      cmd(CMD_SETMAX, FEAT_LOCK, 8'h00);
      cmd(CMD_SETMAX, FEAT_FREEZE, 8'h00);
      stat_is(16'h0050);
      check(32'(max_state), 32'(MAX_FROZ));
      for (int k = 0; k < 3; k++) begin
         cmd(CMD_SETMAX, bad[k], 8'h00);
         stat_is(16'h0451);
      end
      cmd(CMD_RD_NATIVE, 8'h00, 8'h00);
      cmd(CMD_SETMAX, FEAT_FREEZE, 8'h00);
      stat_is(16'h0451);
      $display("test max limit done");
      nspin = 0;
      cmd(CMD_SLEEP_A, 8'h00, 8'h00);
      check(32'(sleeping), 32'h1);
      check(nspin, 1);
      cmd(CMD_SETMULT, 8'h00, BLK_8);
      check(32'(mult_blk), 32'(BLK_4));
      wrs(A_CTRL, 32'h1 << CTRL_SRST);
      check(32'(sleeping), 32'h0);
      spun_down <= 1'b1;
      nspin = 0;
      cmd(CMD_SLEEP_B, 8'h00, 8'h00);
      check(nspin, 0);
      wrs(A_CTRL, 32'h1 << CTRL_HRST);
      check(32'(sleeping), 32'h0);
      $display("test sleep done");
      final_report();
   end
endmodule : tb
